// ==== design/synth_freq_pkg.sv ====
// Constants, types and register map of the synthesizer frequency control block.
package synth_freq_pkg;

    localparam logic [6:0] ADDR_OFFSET_LOW = 7'h73;
    localparam logic [6:0] ADDR_OFFSET_HIGH = 7'h74;
    localparam logic [6:0] ADDR_BAND_SELECT = 7'h75;
    localparam logic [6:0] ADDR_CARRIER_HIGH = 7'h76;
    localparam logic [6:0] ADDR_CARRIER_LOW = 7'h77;
    localparam logic [6:0] ADDR_HOP_CHANNEL = 7'h79;
    localparam logic [6:0] ADDR_HOP_STEP = 7'h7A;

    localparam logic [7:0] RST_OFFSET_LOW = 8'h00;
    localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;
    localparam logic [7:0] RST_BAND_SELECT = 8'h35;
    localparam logic [7:0] RST_CARRIER_HIGH = 8'hBB;
    localparam logic [7:0] RST_CARRIER_LOW = 8'h80;
    localparam logic [7:0] RST_HOP_CHANNEL = 8'h00;
    localparam logic [7:0] RST_HOP_STEP = 8'h00;

    // Band select register fields.
    localparam int BAND_SUB_BIT = 6;
    localparam int BAND_HIGH_BIT = 5;
    localparam logic [4:0] BAND_MAX = 5'h17;
    localparam logic [5:0] N_BASE = 6'h18;
    localparam int FRAC_MOD = 64000;

    // Clock, reference and frequency units.
    localparam int CLK_FREQ_MHZ = 100;
    localparam int REF_FREQ_MHZ = 10;
    localparam int REF_DIV = CLK_FREQ_MHZ / REF_FREQ_MHZ;
    localparam int REF_HZ = REF_FREQ_MHZ * 1000000;
    localparam int RX_SHIFT_HZ = 937500;
    localparam int HOP_UNIT_HZ = 10000;
    localparam int DEV_UNIT_HZ = 625;
    // Fraction steps per unit in low band; high band needs half as many.
    localparam int RX_SHIFT_LB = RX_SHIFT_HZ * (FRAC_MOD / 1000) / (REF_HZ / 1000);
    localparam int HOP_UNITS_LB = HOP_UNIT_HZ * (FRAC_MOD / 1000) / (REF_HZ / 1000);
    localparam int DEV_UNITS_LB = DEV_UNIT_HZ * (FRAC_MOD / 1000) / (REF_HZ / 1000);

    // Start-up sequence timing in microseconds.
    localparam int TOTAL_SEQ_US = 200;
    localparam int SETTLE_US = 100;
    localparam int BIAS_SETTLE_US = 50;
    localparam int CAL_US = TOTAL_SEQ_US - SETTLE_US - BIAS_SETTLE_US;
    localparam int BIAS_CYCLES_DEF = BIAS_SETTLE_US * CLK_FREQ_MHZ;
    localparam int CAL_CYCLES_DEF = CAL_US * CLK_FREQ_MHZ;
    localparam int SETTLE_CYCLES_DEF = SETTLE_US * CLK_FREQ_MHZ;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'h0,
        MODE_TUNE = 2'h1,
        MODE_TX = 2'h2,
        MODE_RX = 2'h3
    } mode_e;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_BIAS = 7'h02,
        S_CAL = 7'h04,
        S_SETTLE = 7'h08,
        S_TUNE = 7'h10,
        S_TX = 7'h20,
        S_RX = 7'h40
    } state_e;

endpackage

// ==== design/synth_freq_ctrl.sv ====
// Frequency word, delta-sigma modulator and PLL start sequencer of the synthesizer.
`timescale 1ns/1ps
`default_nettype none

module synth_freq_ctrl
    import synth_freq_pkg::*;
#(
    parameter int BIAS_CYCLES = BIAS_CYCLES_DEF,
    parameter int CAL_CYCLES = CAL_CYCLES_DEF,
    parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
)
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic [6:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WE,
    input wire logic [1:0] I_MODE_REQ,
    input wire logic I_FAST_TURNAROUND,
    input wire logic I_TX_PACKET_BUSY,
    input wire logic I_TX_DATA,
    input wire logic [8:0] I_DEVIATION_FIELD,
    output logic [7:0] O_REG_RDATA,
    output logic [6:0] O_STAGE,
    output logic O_SETTLED,
    output logic O_LOW_BAND_DIV2,
    output logic [6:0] O_SYNTH_INT,
    output logic [15:0] O_SYNTH_FRAC,
    output logic [7:0] O_DIV_RATIO
);

    // One accumulator stage of the modulator: returns carry and the wrapped sum.
    function automatic logic [16:0] acc_step(input logic [15:0] acc, input logic [15:0] inc);
        logic [16:0] sum;
        sum = {1'b0, acc} + {1'b0, inc};
        if (sum >= 17'(FRAC_MOD))
        begin
            acc_step = {1'b1, 16'(sum - 17'(FRAC_MOD))};
        end
        else
        begin
            acc_step = {1'b0, sum[15:0]};
        end
    endfunction

    function automatic state_e mode_state(input mode_e m);
        unique case (m)
            MODE_IDLE: mode_state = S_IDLE;
            MODE_TUNE: mode_state = S_TUNE;
            MODE_TX: mode_state = S_TX;
            MODE_RX: mode_state = S_RX;
        endcase
    endfunction

    logic [7:0] offset_low_byte;
    logic [1:0] offset_high_bits;
    logic [4:0] band_integer_field;
    logic high_band;
    logic sub_band;
    logic [7:0] carrier_fraction_high;
    logic [7:0] carrier_fraction_low;
    logic [7:0] hop_channel_number;
    logic [7:0] hop_step_size;

    state_e state;
    state_e next_state;
    mode_e goal;
    mode_e next_goal;
    mode_e mode_req;
    logic [15:0] timer;
    logic [15:0] next_timer;
    logic timer_done;
    logic load_seq;
    logic freq_pending;
    logic [24:0] tuned_word;

    logic [3:0] ref_count;
    logic ref_tick;
    logic [15:0] acc1;
    logic [15:0] acc2;
    logic [15:0] acc3;
    logic c2_d;
    logic c3_d;
    logic c3_dd;

    // Register write decode.
    logic wr_off_lo;
    logic wr_off_hi;
    logic wr_band;
    logic wr_car_hi;
    logic wr_car_lo;
    logic wr_hop_ch;
    logic wr_hop_step;
    logic freq_write;
    logic [4:0] band_wr_value;

    assign wr_off_lo = I_REG_WE && (I_REG_ADDR == ADDR_OFFSET_LOW);
    assign wr_off_hi = I_REG_WE && (I_REG_ADDR == ADDR_OFFSET_HIGH);
    assign wr_band = I_REG_WE && (I_REG_ADDR == ADDR_BAND_SELECT);
    assign wr_car_hi = I_REG_WE && (I_REG_ADDR == ADDR_CARRIER_HIGH);
    assign wr_car_lo = I_REG_WE && (I_REG_ADDR == ADDR_CARRIER_LOW);
    assign wr_hop_ch = I_REG_WE && (I_REG_ADDR == ADDR_HOP_CHANNEL);
    assign wr_hop_step = I_REG_WE && (I_REG_ADDR == ADDR_HOP_STEP);
    assign freq_write = wr_off_lo | wr_off_hi | wr_band | wr_car_hi | wr_car_lo | wr_hop_ch | wr_hop_step;
    assign band_wr_value = (I_REG_WDATA[4:0] > BAND_MAX) ? BAND_MAX : I_REG_WDATA[4:0];

    // Register read mux; unmapped addresses and reserved bits read zero.
    logic [7:0] rd_value;
    logic [7:0] band_read;

    assign band_read = {1'b0, sub_band, high_band, band_integer_field};
    assign rd_value = (I_REG_ADDR == ADDR_OFFSET_LOW) ? offset_low_byte :
                      (I_REG_ADDR == ADDR_OFFSET_HIGH) ? {6'h00, offset_high_bits} :
                      (I_REG_ADDR == ADDR_BAND_SELECT) ? band_read :
                      (I_REG_ADDR == ADDR_CARRIER_HIGH) ? carrier_fraction_high :
                      (I_REG_ADDR == ADDR_CARRIER_LOW) ? carrier_fraction_low :
                      (I_REG_ADDR == ADDR_HOP_CHANNEL) ? hop_channel_number :
                      (I_REG_ADDR == ADDR_HOP_STEP) ? hop_step_size : 8'h00;

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            offset_low_byte <= RST_OFFSET_LOW;
            offset_high_bits <= RST_OFFSET_HIGH[1:0];
            band_integer_field <= RST_BAND_SELECT[4:0];
            high_band <= RST_BAND_SELECT[BAND_HIGH_BIT];
            sub_band <= RST_BAND_SELECT[BAND_SUB_BIT];
            carrier_fraction_high <= RST_CARRIER_HIGH;
            carrier_fraction_low <= RST_CARRIER_LOW;
            hop_channel_number <= RST_HOP_CHANNEL;
            hop_step_size <= RST_HOP_STEP;
            O_REG_RDATA <= 8'h00;
        end
        else
        begin
            if (wr_off_lo) offset_low_byte <= I_REG_WDATA;
            if (wr_off_hi) offset_high_bits <= I_REG_WDATA[1:0];
            if (wr_band)
            begin
                band_integer_field <= band_wr_value;
                high_band <= I_REG_WDATA[BAND_HIGH_BIT];
                sub_band <= I_REG_WDATA[BAND_SUB_BIT];
            end
            if (wr_car_hi) carrier_fraction_high <= I_REG_WDATA;
            if (wr_car_lo) carrier_fraction_low <= I_REG_WDATA;
            if (wr_hop_ch) hop_channel_number <= I_REG_WDATA;
            if (wr_hop_step) hop_step_size <= I_REG_WDATA;
            O_REG_RDATA <= rd_value;
        end
    end

    // Nominal word in fraction steps of 10 MHz times (high band + 1) over 64000.
    logic [15:0] carrier_fraction_field;
    logic [9:0] offset_trim_field;
    logic [15:0] hop_product;
    logic [24:0] integer_word;
    logic [24:0] hop_word;
    logic [24:0] nominal_word;

    assign carrier_fraction_field = {carrier_fraction_high, carrier_fraction_low};
    assign offset_trim_field = {offset_high_bits, offset_low_byte};
    assign integer_word = 25'({1'b0, band_integer_field} + N_BASE) * 25'(FRAC_MOD);
    assign hop_product = hop_step_size * hop_channel_number;
    assign hop_word = 25'(hop_product) * 25'(high_band ? HOP_UNITS_LB / 2 : HOP_UNITS_LB);
    assign nominal_word = integer_word + 25'(carrier_fraction_field)
                        + {{15{offset_trim_field[9]}}, offset_trim_field}
                        + hop_word;

    // Live word: receive shift and FSK deviation applied on the latched tuning.
    logic [24:0] rx_shift;
    logic [24:0] dev_word;
    logic [24:0] fsk_word;
    logic [24:0] synth_word;
    logic [24:0] synth_pos;

    assign rx_shift = (goal == MODE_RX) ? 25'(high_band ? RX_SHIFT_LB / 2 : RX_SHIFT_LB) : 25'h0000000;
    assign dev_word = 25'(I_DEVIATION_FIELD) * 25'(high_band ? DEV_UNITS_LB / 2 : DEV_UNITS_LB);
    assign fsk_word = (state != S_TX) ? 25'h0000000 : (I_TX_DATA ? dev_word : 25'(0) - dev_word);
    assign synth_word = tuned_word - rx_shift + fsk_word;
    assign synth_pos = synth_word[24] ? 25'h0000000 : synth_word;

    // Sequencer.
    assign mode_req = mode_e'(I_MODE_REQ);
    assign timer_done = (timer == 16'h0000);

    always_comb
    begin
        next_state = state;
        next_goal = goal;
        load_seq = 1'b0;
        unique case (state)
            S_IDLE:
            begin
                if (mode_req != MODE_IDLE)
                begin
                    next_goal = mode_req;
                    load_seq = 1'b1;
                    next_state = I_FAST_TURNAROUND ? S_SETTLE : S_BIAS;
                end
            end
            S_BIAS:
            begin
                if (timer_done) next_state = S_CAL;
            end
            S_CAL:
            begin
                if (timer_done) next_state = S_SETTLE;
            end
            S_SETTLE:
            begin
                if (timer_done) next_state = mode_state(goal);
            end
            S_TUNE, S_TX, S_RX:
            begin
                if (mode_req == MODE_IDLE)
                begin
                    next_goal = MODE_IDLE;
                    next_state = S_IDLE;
                end
                else if (freq_pending && !(state == S_TX && I_TX_PACKET_BUSY))
                begin
                    next_goal = mode_req;
                    load_seq = 1'b1;
                    next_state = I_FAST_TURNAROUND ? S_SETTLE : S_BIAS;
                end
                else if (mode_req != goal)
                begin
                    next_goal = mode_req;
                    next_state = ((mode_req == MODE_RX) != (goal == MODE_RX)) ? S_SETTLE : mode_state(mode_req);
                end
            end
        endcase
    end

    always_comb
    begin
        next_timer = timer_done ? timer : timer - 16'h0001;
        if (next_state != state)
        begin
            unique case (next_state)
                S_BIAS: next_timer = 16'(BIAS_CYCLES - 1);
                S_CAL: next_timer = 16'(CAL_CYCLES - 1);
                S_SETTLE: next_timer = 16'(SETTLE_CYCLES - 1);
                S_IDLE, S_TUNE, S_TX, S_RX: next_timer = 16'h0000;
            endcase
        end
    end

    // Reset starts the power-up calibration sequence.
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            state <= S_BIAS;
            goal <= MODE_IDLE;
            timer <= 16'(BIAS_CYCLES - 1);
            freq_pending <= 1'b0;
            tuned_word <= 25'h0000000;
            O_SETTLED <= 1'b0;
            O_LOW_BAND_DIV2 <= 1'b0;
        end
        else
        begin
            state <= next_state;
            goal <= next_goal;
            timer <= next_timer;
            freq_pending <= freq_write | (freq_pending & ~load_seq);
            if (load_seq || state == S_BIAS) tuned_word <= nominal_word;
            O_SETTLED <= (next_state == S_TUNE) || (next_state == S_TX) || (next_state == S_RX);
            O_LOW_BAND_DIV2 <= ~high_band;
        end
    end

    assign O_STAGE = state;

    // Reference-rate enable and third-order modulator.
    logic [16:0] step1;
    logic [16:0] step2;
    logic [16:0] step3;
    logic [3:0] corr;

    assign ref_tick = (ref_count == 4'(REF_DIV - 1));
    assign step1 = acc_step(acc1, O_SYNTH_FRAC);
    assign step2 = acc_step(acc2, step1[15:0]);
    assign step3 = acc_step(acc3, step2[15:0]);
    assign corr = 4'(step1[16]) + 4'(step2[16]) - 4'(c2_d) + 4'(step3[16]) - {2'b00, c3_d, 1'b0} + 4'(c3_dd);

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            ref_count <= 4'h0;
            O_SYNTH_INT <= 7'h00;
            O_SYNTH_FRAC <= 16'h0000;
        end
        else
        begin
            ref_count <= ref_tick ? 4'h0 : ref_count + 4'h1;
            O_SYNTH_INT <= 7'(synth_pos / 25'(FRAC_MOD));
            O_SYNTH_FRAC <= 16'(synth_pos % 25'(FRAC_MOD));
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            acc1 <= 16'h0000;
            acc2 <= 16'h0000;
            acc3 <= 16'h0000;
            c2_d <= 1'b0;
            c3_d <= 1'b0;
            c3_dd <= 1'b0;
            O_DIV_RATIO <= 8'h00;
        end
        else if (ref_tick)
        begin
            acc1 <= step1[15:0];
            acc2 <= step2[15:0];
            acc3 <= step3[15:0];
            c2_d <= step2[16];
            c3_d <= step3[16];
            c3_dd <= c3_d;
            O_DIV_RATIO <= {1'b0, O_SYNTH_INT} + {{4{corr[3]}}, corr};
        end
    end

endmodule

`default_nettype wire

// ==== dv/synth_freq_ctrl_sva.sv ====
// Port assertions of the synthesizer frequency control block.
`timescale 1ns/1ps
`default_nettype none
module synth_freq_ctrl_sva
    import synth_freq_pkg::*;
#(
    parameter int BIAS_CYCLES = 5,
    parameter int CAL_CYCLES = 5,
    parameter int SETTLE_CYCLES = 10
)
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic [6:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WE,
    input wire logic [1:0] I_MODE_REQ,
    input wire logic I_FAST_TURNAROUND,
    input wire logic I_TX_PACKET_BUSY,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic [6:0] O_STAGE,
    input wire logic O_SETTLED,
    input wire logic O_LOW_BAND_DIV2,
    input wire logic [15:0] O_SYNTH_FRAC,
    input wire logic [6:0] O_SYNTH_INT,
    input wire logic [7:0] O_DIV_RATIO
);
    int cnt;
    logic [6:0] last;
    logic seen_idle;
    wire logic mapped = I_REG_ADDR inside {7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h79, 7'h7A};
    wire logic done = O_STAGE inside {S_TUNE, S_TX, S_RX};
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Counts consecutive samples of one stage; the power-up bias wait is not measured.
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            cnt <= 0;
            last <= S_BIAS;
            seen_idle <= 1'b0;
        end
        else
        begin
            cnt <= (O_STAGE == last) ? cnt + 1 : 1;
            last <= O_STAGE;
            seen_idle <= seen_idle | (O_STAGE == S_IDLE);
        end
    end
    a_settled_stage: assert property (O_SETTLED == done)
        else $error("settled flag disagrees with stage");
    a_bias_length: assert property (seen_idle && last == S_BIAS && O_STAGE != S_BIAS |-> cnt == BIAS_CYCLES)
        else $error("bias wait length wrong");
    a_cal_length: assert property (last == S_CAL && O_STAGE != S_CAL |-> cnt == CAL_CYCLES)
        else $error("calibration length wrong");
    a_settle_length: assert property (last == S_SETTLE && O_STAGE != S_SETTLE |-> cnt == SETTLE_CYCLES)
        else $error("settling wait length wrong");
    a_default_start: assert property (O_STAGE == S_IDLE && I_MODE_REQ != 2'h0 && !I_FAST_TURNAROUND
        |=> O_STAGE == S_BIAS)
        else $error("start did not begin with bias wait");
    a_fast_skip: assert property (O_STAGE == S_IDLE && I_MODE_REQ != 2'h0 && I_FAST_TURNAROUND
        |=> O_STAGE == S_SETTLE)
        else $error("fast start did not skip to settling");
    a_mode_exit: assert property (done && I_MODE_REQ == 2'h0 && !I_REG_WE |=> O_STAGE == S_IDLE)
        else $error("idle request not honoured");
    a_tx_hold: assert property (O_STAGE == S_TX && I_TX_PACKET_BUSY && I_MODE_REQ == 2'h2 |=> O_STAGE == S_TX)
        else $error("left transmit during a packet");
    a_div2_follow: assert property (I_REG_WE && I_REG_ADDR == 7'h75
        |-> ##2 O_LOW_BAND_DIV2 == !$past(I_REG_WDATA[5], 2))
        else $error("divide-by-two select wrong");
    a_band_clamp: assert property (I_REG_WE && I_REG_ADDR == 7'h75 && I_REG_WDATA[4:0] > 5'h17
        ##1 I_REG_ADDR == 7'h75 && !I_REG_WE |=> O_REG_RDATA[4:0] == 5'h17)
        else $error("band field not clamped");
    a_unmapped_zero: assert property (!mapped |=> O_REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_frac_range: assert property (O_SYNTH_FRAC < 16'hFA00)
        else $error("fraction outside modulus");
    // A third-order modulator moves the divider by at most three below and four above the integer ratio.
    a_div_ratio_range: assert property ($changed(O_DIV_RATIO) |-> (O_DIV_RATIO + 8'h03 >= {1'b0, $past(O_SYNTH_INT)})
        && (O_DIV_RATIO <= {1'b0, $past(O_SYNTH_INT)} + 8'h04))
        else $error("divider ratio outside modulator range");
endmodule
bind synth_freq_ctrl synth_freq_ctrl_sva #(
    .BIAS_CYCLES(BIAS_CYCLES),
    .CAL_CYCLES(CAL_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
) synth_freq_ctrl_sva_i (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_REG_WE(I_REG_WE), .I_MODE_REQ(I_MODE_REQ), .I_FAST_TURNAROUND(I_FAST_TURNAROUND),
    .I_TX_PACKET_BUSY(I_TX_PACKET_BUSY), .O_REG_RDATA(O_REG_RDATA), .O_STAGE(O_STAGE),
    .O_SETTLED(O_SETTLED), .O_LOW_BAND_DIV2(O_LOW_BAND_DIV2), .O_SYNTH_FRAC(O_SYNTH_FRAC),
    .O_SYNTH_INT(O_SYNTH_INT), .O_DIV_RATIO(O_DIV_RATIO)
);
`default_nettype wire

// ==== dv/host_model.sv ====
// Host controller model that writes registers, reads them and requests modes.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic i_clk,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_we,
    output logic o_rd,
    output logic [1:0] o_mode
);
    initial
    begin
        o_addr = 7'h00;
        o_wdata = 8'h00;
        o_we = 1'b0;
        o_rd = 1'b0;
        o_mode = 2'h0;
    end
    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_we <= 1'b1;
        o_rd <= 1'b0;
    endtask
    task automatic read_reg(input logic [6:0] a);
        @(posedge i_clk);
        o_addr <= a;
        o_we <= 1'b0;
        o_rd <= 1'b1;
    endtask
    // Released write data is inverted so a stale value cannot pass for fresh data.
    task automatic rest();
        @(posedge i_clk);
        o_we <= 1'b0;
        o_rd <= 1'b0;
        o_wdata <= ~o_wdata;
    endtask
    task automatic set_mode(input logic [1:0] m);
        @(posedge i_clk);
        o_mode <= m;
    endtask
endmodule
`default_nettype wire

// ==== dv/synth_freq_ctrl_test.sv ====
// Self-checking bench of the synthesizer frequency control block.
`timescale 1ns/1ps
`default_nettype none
module synth_freq_ctrl_test
    import synth_freq_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic fast = 1'b0;
    logic busy = 1'b0;
    logic tx_data = 1'b0;
    logic [8:0] dev = 9'h000;
    logic [7:0] rnd = 8'h14;
    logic [15:0] f;
    wire logic [6:0] addr;
    wire logic [7:0] wdata;
    wire logic we, rd;
    wire logic [1:0] mode;
    logic [7:0] rdata;
    logic [6:0] stage, s_int;
    logic settled, div2;
    logic [15:0] s_frac;
    logic [7:0] div_ratio;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic rd_d = 1'b0;
    logic [1:0] set_d = 2'h0;
    logic [7:0] rd_q[$];
    logic [22:0] word_q[$];
    initial
    begin
        forever #5 clk = ~clk;
    end
    host_model host_model_i (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_we(we), .o_rd(rd), .o_mode(mode));
    synth_freq_ctrl #(.BIAS_CYCLES(5), .CAL_CYCLES(5), .SETTLE_CYCLES(10)) synth_freq_ctrl_i (
        .I_CLK(clk), .I_RESET_N(reset_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WE(we),
        .I_MODE_REQ(mode), .I_FAST_TURNAROUND(fast), .I_TX_PACKET_BUSY(busy), .I_TX_DATA(tx_data),
        .I_DEVIATION_FIELD(dev), .O_REG_RDATA(rdata), .O_STAGE(stage), .O_SETTLED(settled),
        .O_LOW_BAND_DIV2(div2), .O_SYNTH_INT(s_int), .O_SYNTH_FRAC(s_frac), .O_DIV_RATIO(div_ratio));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input logic [22:0] got, input logic [22:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic rdx(input logic [6:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        host_model_i.read_reg(a);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_model_i.write_reg(a, d);
    endtask
    task automatic go(input logic [1:0] m);
        host_model_i.rest();
        host_model_i.set_mode(m);
        for (int n = 0; n < 200 && word_q.size() != 0; n++)
            @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    // Results are taken one cycle after settling so the word has caught up with the stage.
    always @(posedge clk)
    begin
        rd_d <= rd;
        set_d <= {set_d[0], settled};
        cycles <= cycles + 1;
        if (rd_d)
            check({15'h0000, rdata}, {15'h0000, rd_q.pop_front()});
        if (set_d == 2'h1)
            check({s_int, s_frac}, word_q.pop_front());
        if (cycles == 3000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        for (int n = 0; n < 100 && stage !== S_IDLE; n++)
            @(posedge clk);
        rdx(7'h73, 8'h00);
        rdx(7'h74, 8'h00);
        rdx(7'h75, 8'h35);
        rdx(7'h76, 8'hBB);
        rdx(7'h77, 8'h80);
        rdx(7'h79, 8'h00);
        rdx(7'h7A, 8'h00);
        rdx(7'h78, 8'h00);
        word_q.push_back({7'h2D, 16'hBB80});
        go(2'h1);
        word_q.push_back({7'h2F, 16'hBB80});
        wr(7'h75, 8'h3F);
        rdx(7'h75, 8'h37);
        go(2'h1);
        go(2'h0);
        wr(7'h73, 8'h05);
        wr(7'h76, 8'h00);
        wr(7'h77, 8'h00);
        wr(7'h75, 8'h14);
        wr(7'h7A, 8'h02);
        word_q.push_back({7'h2C, 16'h0005});
        fast <= 1'b1;
        go(2'h1);
        word_q.push_back({7'h2C, 16'h0185});
        wr(7'h79, 8'h03);
        go(2'h1);
        rnd = lfsr(rnd);
        dev <= {4'h0, rnd[4:0]};
        tx_data <= rnd[7];
        go(2'h2);
        word_q.push_back({7'h2B, 16'hE415});
        go(2'h3);
        f = rnd[7] ? 16'h0185 + {9'h000, rnd[4:0], 2'h0} : 16'h0185 - {9'h000, rnd[4:0], 2'h0};
        word_q.push_back({7'h2C, f});
        go(2'h2);
        busy <= 1'b1;
        wr(7'h79, 8'h01);
        host_model_i.rest();
        repeat (40) @(posedge clk);
        f = rnd[7] ? 16'h0085 + {9'h000, rnd[4:0], 2'h0} : 16'h0085 - {9'h000, rnd[4:0], 2'h0};
        word_q.push_back({7'h2C, f});
        fast <= 1'b0;
        busy <= 1'b0;
        go(2'h2);
        if (word_q.size() != 0)
            errors++;
        conclude();
    end
endmodule
`default_nettype wire
